// ===== common/eeprom_front_consts.vh
// constants for the two-wire eeprom slave front end
`ifndef EEPROM_FRONT_CONSTS_VH
`define EEPROM_FRONT_CONSTS_VH
// fixed upper nibble of the command byte; the value is arbitrary
`define CMD_FAMILY_CODE      4'h6
`define CMD_FAMILY_MSB       7
`define CMD_FAMILY_LSB       4
`define CMD_STRAP_MSB        3
`define CMD_STRAP_LSB        1
`define CMD_DIR_BIT          0
`define ADDR_WIDTH           13
`define ADDR_HIGH_BITS       5
`define PAGE_OFFSET_BITS     5
`define MEM_BYTES            8192
`define PAGE_BYTES           32
`define PROG_TIME_NS         5000000
`define CLK_PERIOD_NS        5
`define PROG_CYCLES          (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_VALUE          8'hFF
`define BIT_COUNT_RESET      4'h0
`endif

// ===== design/eeprom_bus_slave.v
// two-wire bus slave front end of an 8192-byte page-programmed eeprom
`timescale 1ns/1ps
`include "eeprom_front_consts.vh"
// What this block does
// - sample on scl rise, drive on fall
// - sda only pulled low or released
// - start is sda falling, scl high
// - stop is sda rising, ends communication
// - stop after written data starts programming
// - stop after read goes standby
// - after programming return idle, lines released
// - receiver acks low during ninth clock
// - transmitter releases sda after eighth bit
// - ack received bytes only when addressed
// - sda changes only while scl low
// - bits three..one match chip-select straps
// - bit zero selects write or read
// - read continues while master acknowledges
// - write protect high blocks memory changes
// - 8192 bytes, 256 pages of 32
// - program one byte or up to 32
// - self-timed erase then write cycle
// - address bytes load the address counter
// - counter advances after read or written byte
// - page write wraps low five bits
// - no command ack while programming
module eeprom_bus_slave #(
    parameter PROG_CYCLES = `PROG_CYCLES,
    parameter AW          = `ADDR_WIDTH
) (
    input  wire       clk_sys,
    input  wire       sys_rst,
    input  wire       clkEn,
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOut,
    output reg        sdaOe,
    input  wire       chip_select_strap_bit0,
    input  wire       chip_select_strap_bit1,
    input  wire       chip_select_strap_bit2,
    input  wire       writeProtect,
    output reg        programBusy,
    output reg        memWriteEn,
    output reg  [12:0] memAddr,
    output reg  [7:0] memWriteData,
    input  wire [7:0] memReadData
);
    // ************************************************************
    // states
    // ************************************************************
    localparam [5:0] ST_IDLE    = 6'h01;
    localparam [5:0] ST_COMMAND = 6'h02;
    localparam [5:0] ST_ADDR_HI = 6'h04;
    localparam [5:0] ST_ADDR_LO = 6'h08;
    localparam [5:0] ST_WDATA   = 6'h10;
    localparam [5:0] ST_RDATA   = 6'h20;
    localparam [2:0] PG_IDLE  = 3'h1;
    localparam [2:0] PG_ERASE = 3'h2;
    localparam [2:0] PG_WRITE = 3'h4;
    localparam [31:0] PROG_LAST = PROG_CYCLES - 1;
    localparam [31:0] HALF_LAST = PROG_CYCLES / 2 - 1;

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    reg  [1:0] sclSync;
    reg  [1:0] sdaSync;
    reg        sclPrev;
    reg        sdaPrev;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (clkEn) begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end
    wire sclRise = clkEn & sclSync[1] & ~sclPrev;
    wire sclFall = clkEn & ~sclSync[1] & sclPrev;
    // scl must be steady high across the sda edge, else it is ordinary data
    wire startSeen = clkEn & sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
    wire stopSeen  = clkEn & sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

    function strapMatch;
        input [7:0] b;
        input [2:0] straps;
        begin
            strapMatch = (b[`CMD_FAMILY_MSB:`CMD_FAMILY_LSB] == `CMD_FAMILY_CODE) &&
                         (b[`CMD_STRAP_MSB:`CMD_STRAP_LSB] == straps);
        end
    endfunction

    // ************************************************************
    // bit engine
    // ************************************************************
    reg  [5:0]  state;
    reg  [3:0]  bitCount;
    reg  [7:0]  shiftIn;
    reg  [7:0]  shiftOut;
    reg         ackPhase;
    reg         masterAck;
    reg         wroteData;
    reg  [AW-1:0] addrCount;
    reg  [2:0]  strapLatch;
    reg  [2:0]  pgState;
    reg  [31:0] pgTimer;
    reg  [4:0]  pgIdx;
    reg  [AW-1:0] pageBase;
    reg         bufWrite;
    reg  [4:0]  bufIdx;
    reg  [7:0]  bufData;
    wire [7:0]  bufReadData;
    wire        bufReadValid;
    wire [7:0]  rxByte = {shiftIn[6:0], sdaSync[1]};
    reg         pgStart;

    // straps are slow pins: capture through the same two-flop path
    reg [2:0] strapSync0;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            strapSync0 <= 3'h0;
            strapLatch <= 3'h0;
        end else if (clkEn) begin
            strapSync0 <= {chip_select_strap_bit2, chip_select_strap_bit1, chip_select_strap_bit0};
            strapLatch <= strapSync0;
        end
    end
    reg [1:0] wpSync;
    always @(posedge clk_sys) begin
        if (sys_rst)
            wpSync <= 2'h0;
        else if (clkEn)
            wpSync <= {wpSync[0], writeProtect};
    end

    assign sdaOut = 1'b0;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state     <= ST_IDLE;
            bitCount  <= `BIT_COUNT_RESET;
            shiftIn   <= 8'h00;
            shiftOut  <= 8'h00;
            ackPhase  <= 1'b0;
            masterAck <= 1'b0;
            sdaOe     <= 1'b0;
            wroteData <= 1'b0;
            addrCount <= {AW{1'b0}};
            bufWrite  <= 1'b0;
            bufIdx    <= 5'h00;
            bufData   <= 8'h00;
            pgStart   <= 1'b0;
            pageBase  <= {AW{1'b0}};
        end else if (clkEn) begin
            bufWrite <= 1'b0;
            pgStart  <= 1'b0;
            if (startSeen) begin
                state     <= ST_COMMAND;
                bitCount  <= `BIT_COUNT_RESET;
                ackPhase  <= 1'b0;
                sdaOe     <= 1'b0;
                wroteData <= 1'b0;
            end else if (stopSeen) begin
                state <= ST_IDLE;
                sdaOe <= 1'b0;
                if (wroteData && !wpSync[1])
                    pgStart <= 1'b1;
                wroteData <= 1'b0;
            end else if (state != ST_IDLE) begin
                if (sclRise) begin
                    if (!ackPhase) begin
                        shiftIn  <= rxByte;
                        bitCount <= bitCount + 4'h1;
                    end else begin
                        masterAck <= ~sdaSync[1];
                    end
                end else if (sclFall) begin
                    if (ackPhase) begin
                        // ninth clock done: release, then either send or listen
                        ackPhase <= 1'b0;
                        bitCount <= `BIT_COUNT_RESET;
                        sdaOe    <= 1'b0;
                        if (state == ST_RDATA) begin
                            if (sdaOe || masterAck) begin
                                shiftOut  <= memReadData;
                                sdaOe     <= ~memReadData[7];
                                addrCount <= addrCount + 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end else if (bitCount == 4'h8) begin
                        ackPhase <= 1'b1;
                        sdaOe    <= 1'b0;
                        case (state)
                            ST_COMMAND: begin
                                if (strapMatch(shiftIn, strapLatch) && !programBusy) begin
                                    sdaOe <= 1'b1;
                                    state <= shiftIn[`CMD_DIR_BIT] ? ST_RDATA : ST_ADDR_HI;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end
                            ST_ADDR_HI: begin
                                sdaOe <= 1'b1;
                                addrCount[AW-1:8] <= shiftIn[`ADDR_HIGH_BITS-1:0];
                                state <= ST_ADDR_LO;
                            end
                            ST_ADDR_LO: begin
                                sdaOe <= 1'b1;
                                addrCount[7:0] <= shiftIn;
                                state <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                sdaOe    <= 1'b1;
                                bufWrite <= 1'b1;
                                bufIdx   <= addrCount[4:0];
                                bufData  <= shiftIn;
                                pageBase <= {addrCount[AW-1:5], 5'h00};
                                wroteData <= 1'b1;
                                addrCount <= {addrCount[AW-1:5], addrCount[4:0] + 5'h01};
                            end
                            ST_RDATA: begin
                                sdaOe <= 1'b0;
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end else if (state == ST_RDATA && bitCount != `BIT_COUNT_RESET) begin
                        shiftOut <= {shiftOut[6:0], 1'b0};
                        sdaOe    <= ~shiftOut[6];
                    end
                end
            end
        end
    end

    // ************************************************************
    // self-timed erase/write of buffered page bytes
    // ************************************************************
    page_write_buffer #(
        .DEPTH    (`PAGE_BYTES),
        .IDX_BITS (`PAGE_OFFSET_BITS)
    ) pageBuf (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .clkEn     (clkEn),
        // protected or abandoned bytes must not ride into a later cycle
        .clearAll  ((pgState == PG_WRITE && pgTimer == PROG_LAST) || (startSeen && !programBusy)),
        .writeEn   (bufWrite),
        .writeIdx  (bufIdx),
        .writeData (bufData),
        .readIdx   (pgIdx),
        .readData  (bufReadData),
        .readValid (bufReadValid)
    );

    // only bytes that were addressed are erased and written
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pgState      <= PG_IDLE;
            pgTimer      <= 32'h00000000;
            pgIdx        <= 5'h00;
            programBusy  <= 1'b0;
            memWriteEn   <= 1'b0;
            memAddr      <= 13'h0000;
            memWriteData <= 8'h00;
        end else if (clkEn) begin
            memWriteEn <= 1'b0;
            case (pgState)
                PG_IDLE: begin
                    memAddr <= addrCount; // read path follows the counter
                    if (pgStart) begin
                        pgState     <= PG_ERASE;
                        programBusy <= 1'b1;
                        pgTimer     <= 32'h00000000;
                        pgIdx       <= 5'h00;
                    end
                end
                PG_ERASE: begin
                    pgTimer <= pgTimer + 32'h1;
                    pgIdx   <= pgIdx + 5'h01;
                    // first step after pgIdx restarts sees a stale valid flag
                    if (bufReadValid && pgTimer != 32'h0 && pgTimer <= 32'd33) begin
                        memWriteEn   <= 1'b1;
                        memAddr      <= pageBase | {{(AW-5){1'b0}}, pgIdx - 5'h01};
                        memWriteData <= `ERASE_VALUE;
                    end
                    if (pgTimer == HALF_LAST) begin
                        pgState <= PG_WRITE;
                        pgIdx   <= 5'h00;
                    end
                end
                PG_WRITE: begin
                    pgTimer <= pgTimer + 32'h1;
                    pgIdx   <= pgIdx + 5'h01;
                    if (bufReadValid && pgTimer > HALF_LAST + 32'd1 && pgTimer <= HALF_LAST + 32'd33) begin
                        memWriteEn   <= 1'b1;
                        memAddr      <= pageBase | {{(AW-5){1'b0}}, pgIdx - 5'h01};
                        memWriteData <= bufReadData;
                    end
                    if (pgTimer == PROG_LAST) begin
                        pgState     <= PG_IDLE;
                        programBusy <= 1'b0;
                    end
                end
                default: pgState <= PG_IDLE;
            endcase
        end
    end
endmodule

// ===== design/page_write_buffer.v
// page buffer with per-byte valid flags for one programming cycle
`timescale 1ns/1ps
`include "eeprom_front_consts.vh"
module page_write_buffer #(
    parameter DEPTH    = `PAGE_BYTES,
    parameter IDX_BITS = `PAGE_OFFSET_BITS
) (
    input  wire                clk_sys,
    input  wire                sys_rst,
    input  wire                clkEn,
    input  wire                clearAll,
    input  wire                writeEn,
    input  wire [IDX_BITS-1:0] writeIdx,
    input  wire [7:0]          writeData,
    input  wire [IDX_BITS-1:0] readIdx,
    output reg  [7:0]          readData,
    output reg                 readValid
);
    reg [7:0]       store [0:DEPTH-1];
    reg [DEPTH-1:0] filled;
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : slot
            always @(posedge clk_sys) begin
                if (sys_rst) begin
                    store[g]  <= 8'h00;
                    filled[g] <= 1'b0;
                end else if (clkEn) begin
                    if (writeEn && writeIdx == g) begin
                        store[g]  <= writeData;
                        filled[g] <= 1'b1;
                    end else if (clearAll) begin
                        filled[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            readData  <= 8'h00;
            readValid <= 1'b0;
        end else if (clkEn) begin
            readData  <= store[readIdx];
            readValid <= filled[readIdx];
        end
    end
endmodule

// ===== test/eeprom_bus_slave_properties.sv
// port assertions for the eeprom bus slave
`timescale 1ns/1ps
module eeprom_bus_slave_checker #(
    parameter PROG_CYCLES = 200,
    parameter AW          = 13
) (
    input wire        clk_sys,
    input wire        sys_rst,
    input wire        sclIn,
    input wire        sdaIn,
    input wire        sdaOut,
    input wire        sdaOe,
    input wire        writeProtect,
    input wire        programBusy,
    input wire        memWriteEn,
    input wire [12:0] memAddr,
    input wire [7:0]  memWriteData
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ****************
    // bus and programming
    // ****************
    sequence s_stop; sclIn && $rose(sdaIn); endsequence
    sequence s_progStart; $rose(programBusy); endsequence
    sequence s_erase; memWriteEn && memWriteData == 8'hFF; endsequence
    property p_drainOnly; sdaOut == 1'b0; endproperty
    a_drainOnly: assert property (p_drainOnly) else $error("sda driven high");
    // a change while the clock is high would look like a start or stop
    property p_oeSclLow; $changed(sdaOe) |-> !sclIn; endproperty
    a_oeSclLow: assert property (p_oeSclLow) else $error("sda moved with scl high");
    property p_stopQuiet; s_stop |-> ##1 !sdaOe [*8]; endproperty
    a_stopQuiet: assert property (p_stopQuiet) else $error("sda pulled after stop");
    property p_writeInBusy; memWriteEn |-> programBusy; endproperty
    a_writeInBusy: assert property (p_writeInBusy) else $error("write outside cycle");
    property p_eraseFirst; s_progStart |-> ##[0:300] s_erase; endproperty
    a_eraseFirst: assert property (p_eraseFirst) else $error("no erase step");
    property p_busyHold; s_progStart |-> programBusy [*8]; endproperty
    a_busyHold: assert property (p_busyHold) else $error("cycle too short");
    property p_release; $fell(programBusy) |-> !sdaOe [*4]; endproperty
    a_release: assert property (p_release) else $error("sda held after cycle");
    property p_samePage; programBusy && $past(programBusy) |-> memAddr[12:5] == $past(memAddr[12:5]); endproperty
    a_samePage: assert property (p_samePage) else $error("write left the page");
    property p_protect; writeProtect && $past(writeProtect, 8) |-> !$rose(programBusy); endproperty
    a_protect: assert property (p_protect) else $error("protected write started");
    property p_busyNoAck; programBusy |-> !sdaOe; endproperty
    a_busyNoAck: assert property (p_busyNoAck) else $error("ack during cycle");
endmodule
bind eeprom_bus_slave eeprom_bus_slave_checker #(.PROG_CYCLES(PROG_CYCLES), .AW(AW)) u_checker (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .writeProtect(writeProtect), .programBusy(programBusy),
    .memWriteEn(memWriteEn), .memAddr(memAddr), .memWriteData(memWriteData));

// ===== test/eeprom_bus_slave_tb.sv
// self-checking bench for the eeprom bus slave
`timescale 1ns/1ps
`include "eeprom_front_consts.vh"
module eeprom_bus_slave_tb;
    localparam PROG = 200;
    reg         clk_sys;
    reg         sys_rst;
    reg  [2:0]  strap;
    reg         writeProtect;
    reg         clkEn;
    wire        scl;
    wire        sdaDrive;
    wire        sdaOe;
    wire        programBusy;
    wire        memWriteEn;
    wire [12:0] memAddr;
    wire [7:0]  memWriteData;
    wire        sdaLine = sdaDrive & ~sdaOe;
    reg  [7:0]  mem [0:8191];
    reg  [7:0]  model [0:8191];
    reg  [31:0] lfsr;
    reg  [12:0] a;
    reg  [5:0]  n;
    reg  [7:0]  rd;
    reg         ack;
    integer     err_count = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     i;
    integer     k;
    // ****************
    // harness
    // ****************
    two_wire_master u_two_wire_master (.scl(scl), .sdaDrive(sdaDrive), .sdaLine(sdaLine));
    eeprom_bus_slave #(.PROG_CYCLES(PROG)) u_eeprom_bus_slave (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(), .sdaOe(sdaOe), .chip_select_strap_bit0(strap[0]), .chip_select_strap_bit1(strap[1]),
        .chip_select_strap_bit2(strap[2]), .writeProtect(writeProtect), .programBusy(programBusy),
        .memWriteEn(memWriteEn), .memAddr(memAddr), .memWriteData(memWriteData), .memReadData(mem[memAddr]));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (memWriteEn) mem[memAddr] <= memWriteData;
        cycles = cycles + 1;
        if (cycles == 60000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    function [31:0] nextRand(input [31:0] v);
        nextRand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk1(input got, input want);
        begin
            compares = compares + 1;
            if (got !== want) begin
                err_count = err_count + 1;
                $display("[ERR] %0t flag got %b want %b", $time, got, want);
            end
        end
    endtask
    task chk8(input [7:0] got, input [7:0] want);
        begin
            compares = compares + 1;
            if (got !== want) begin
                err_count = err_count + 1;
                $display("[ERR] %0t byte got %h want %h", $time, got, want);
            end
        end
    endtask
    task end_sim;
        begin
            $display("compares %0d errors %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // ****************
    // bus sequences
    // ****************
    task cmd(input dir, output ok);
        begin
            u_two_wire_master.start;
            u_two_wire_master.putByte({`CMD_FAMILY_CODE, strap, dir}, ok);
        end
    endtask
    task setAddr(input [12:0] ad);
        begin
            cmd(1'b0, ack);
            chk1(ack, 1'b1);
            u_two_wire_master.putByte({3'h0, ad[12:8]}, ack);
            chk1(ack, 1'b1);
            u_two_wire_master.putByte(ad[7:0], ack);
            chk1(ack, 1'b1);
        end
    endtask
    task pageWrite(input [12:0] ad, input [5:0] cnt, input wp);
        reg [4:0] off;
        integer   j;
        begin
            setAddr(ad);
            off = ad[4:0];
            for (j = 0; j < cnt; j = j + 1) begin
                lfsr = nextRand(lfsr);
                u_two_wire_master.putByte(lfsr[7:0], ack);
                chk1(ack, 1'b1);
                if (!wp) model[{ad[12:5], off}] = lfsr[7:0];
                off = off + 5'h01;
            end
            u_two_wire_master.stop;
            chk1(programBusy, !wp);
            if (!wp) begin
                cmd(1'b1, ack);
                chk1(ack, 1'b0);
                u_two_wire_master.stop;
                // a frozen clock enable must stretch the cycle
                @(negedge clk_sys);
                clkEn = 1'b0;
                repeat (2 * PROG) @(negedge clk_sys);
                chk1(programBusy, 1'b1);
                clkEn = 1'b1;
            end
            for (j = 0; j < 4 * PROG && programBusy; j = j + 1) @(negedge clk_sys);
            chk1(programBusy, 1'b0);
        end
    endtask
    task readSeq(input [12:0] ad, input [5:0] cnt);
        reg [12:0] p;
        integer    j;
        begin
            setAddr(ad);
            cmd(1'b1, ack);
            chk1(ack, 1'b1);
            p = ad;
            for (j = 0; j < cnt; j = j + 1) begin
                u_two_wire_master.getByte(j < cnt - 1, rd);
                chk8(rd, model[p]);
                p = p + 13'h0001;
            end
            u_two_wire_master.stop;
            chk1(programBusy, 1'b0);
            cmd(1'b1, ack);
            chk1(ack, 1'b1);
            u_two_wire_master.getByte(1'b0, rd);
            chk8(rd, model[p]);
            u_two_wire_master.stop;
        end
    endtask
    initial begin
        lfsr = 32'h802B;
        sys_rst = 1'b1;
        writeProtect = 1'b0;
        clkEn = 1'b1;
        strap = 3'h0;
        for (i = 0; i < 8192; i = i + 1) begin
            lfsr = nextRand(lfsr);
            mem[i] = lfsr[7:0];
            model[i] = lfsr[7:0];
        end
        repeat (3) @(negedge clk_sys);
        strap = lfsr[10:8];
        sys_rst = 1'b0;
        repeat (5) @(negedge clk_sys);
        for (i = 1; i < 8; i = i + 1) begin
            u_two_wire_master.start;
            u_two_wire_master.putByte({`CMD_FAMILY_CODE, strap ^ i[2:0], i[0]}, ack);
            chk1(ack, 1'b0);
            u_two_wire_master.putByte(8'h00, ack);
            chk1(ack, 1'b0);
            u_two_wire_master.stop;
        end
        u_two_wire_master.start;
        u_two_wire_master.putByte({`CMD_FAMILY_CODE ^ 4'h5, strap, 1'b0}, ack);
        chk1(ack, 1'b0);
        u_two_wire_master.stop;
        // first pass forces the in-page wrap, last pass is write protected
        for (k = 0; k < 3; k = k + 1) begin
            lfsr = nextRand(lfsr);
            a = lfsr[12:0];
            n = {1'b0, lfsr[17:13]} + 6'h01;
            if (k == 0) a[4:0] = 5'h1E;
            if (k == 0) n = 6'h04;
            @(negedge clk_sys);
            writeProtect = (k == 2);
            repeat (10) @(negedge clk_sys);
            pageWrite(a, n, k == 2);
            readSeq({a[12:5], 5'h00}, 6'h20);
        end
        end_sim;
    end
endmodule

// ===== test/two_wire_master.sv
// behavioural two-wire master that drives the serial clock
`timescale 1ns/1ps
module two_wire_master (
    output reg  scl,
    output reg  sdaDrive,
    input  wire sdaLine
);
    // ****************
    // bit and byte tasks
    // ****************
    // clock stands high between frames; data moves only mid-low
    initial begin
        scl = 1'b1;
        sdaDrive = 1'b1;
    end
    task putBit(input b);
        begin
            #16 sdaDrive = b;
            #16 scl = 1'b1;
            #32 scl = 1'b0;
        end
    endtask
    task start;
        begin
            #16 sdaDrive = 1'b1;
            #16 scl = 1'b1;
            #16 sdaDrive = 1'b0;
            #16 scl = 1'b0;
        end
    endtask
    task stop;
        begin
            #16 sdaDrive = 1'b0;
            #16 scl = 1'b1;
            #16 sdaDrive = 1'b1;
            #48;
        end
    endtask
    task putByte(input [7:0] d, output ack);
        integer j;
        begin
            for (j = 7; j >= 0; j = j - 1) putBit(d[j]);
            #16 sdaDrive = 1'b1;
            #16 scl = 1'b1;
            #16 ack = !sdaLine;
            #16 scl = 1'b0;
        end
    endtask
    task getByte(input ackIt, output [7:0] d);
        integer j;
        begin
            for (j = 0; j < 8; j = j + 1) begin
                #16 sdaDrive = 1'b1;
                #16 scl = 1'b1;
                #16 d = {d[6:0], sdaLine};
                #16 scl = 1'b0;
            end
            putBit(!ackIt);
        end
    endtask
endmodule
